// file: hw/neutral_unbalance_event_source.sv
// neutral unbalance stage: blocking, definite time, events, records
`default_nettype none
module neutral_unbalance_event_source
  import nub_pkg::*;
#(
  parameter int unsigned CYCLE_LEN = CYCLE_CLKS,
  parameter int unsigned STAMP_W   = 64,
  parameter int unsigned CUR_W     = 16,
  parameter int unsigned FUSE_W    = 8,
  parameter int unsigned GRP_W     = 3,
  parameter int unsigned CNT_W     = 16,
  parameter int unsigned DEPTH     = REC_DEPTH
) (
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  input  wire logic               i_ce,
  input  wire logic               i_alarm_pickup,
  input  wire logic               i_trip_pickup,
  input  wire logic               i_block,
  input  wire logic               i_inrush_en,
  input  wire logic [RATIO_W-1:0] i_harm_ratio,
  input  wire logic [RATIO_W-1:0] i_harm_limit,
  input  wire logic [TIME_W-1:0]  i_alarm_delay,
  input  wire logic [TIME_W-1:0]  i_trip_delay,
  input  wire logic               i_unb_bank_a,
  input  wire logic               i_unb_bank_b,
  input  wire logic               i_compensating,
  input  wire logic [STAMP_W-1:0] i_time_stamp,
  input  wire logic               i_fault_side_b,
  input  wire logic [CUR_W-1:0]   i_unb_current,
  input  wire logic [FUSE_W-1:0]  i_fuse_ops_a,
  input  wire logic [FUSE_W-1:0]  i_fuse_ops_b,
  input  wire logic [GRP_W-1:0]   i_set_group,
  input  wire logic [NUM_EVT-1:0] i_evt_on_en,
  input  wire logic [NUM_EVT-1:0] i_evt_off_en,
  input  wire logic [NUM_CNT-1:0] i_cnt_clear,
  input  wire logic [3:0]         i_rec_idx,
  output logic                    o_alarm_start,
  output logic                    o_alarm,
  output logic                    o_start,
  output logic                    o_trip,
  output logic                    o_blocked,
  output logic [1:0]              o_condition,
  output logic [TIME_W-1:0]       o_trip_remaining,
  output logic [TIME_W-1:0]       o_alarm_remaining,
  output logic                    o_evt_valid,
  output logic [EVC_W-1:0]        o_evt_code,
  output logic [STAMP_W-1:0]      o_evt_stamp,
  output logic [NUM_CNT*CNT_W-1:0] o_counters,
  output logic [3:0]              o_rec_count,
  output logic [STAMP_W-1:0]      o_rec_stamp,
  output logic [1:0]              o_rec_kind,
  output logic                    o_rec_side_b,
  output logic [CUR_W-1:0]        o_rec_current,
  output logic [FUSE_W-1:0]       o_rec_fuse_a,
  output logic [FUSE_W-1:0]       o_rec_fuse_b,
  output logic [TIME_W-1:0]       o_rec_remaining,
  output logic [GRP_W-1:0]        o_rec_group
);

  // ==========================================================
  // elaboration checks
  generate
    if (DEPTH < 1 || DEPTH > 15) begin : g_bad_depth
      $error("record depth must be 1 to 15");
    end
    if (CYCLE_LEN < 2) begin : g_bad_cycle
      $error("program cycle must be at least two clocks");
    end
  endgenerate

  localparam int unsigned CYC_W = $clog2(CYCLE_LEN);
  localparam int unsigned REC_W = STAMP_W + 2 + 1 + CUR_W + 2 * FUSE_W
                                  + TIME_W + GRP_W;

  // rising edge seen between two consecutive clocks
  function automatic logic went_on(input logic was, input logic now);
    went_on = now & ~was;
  endfunction

  // ==========================================================
  // program cycle tick and block sampling
  logic [CYC_W-1:0] cyc_q, cyc_d;
  logic             tick_q, tick_d;
  logic             blk_q, blk_d;

  // block is latched only on the tick so one cycle sees one value
  always_comb begin
    tick_d = 1'b0;
    cyc_d  = cyc_q + 1'b1;
    blk_d  = blk_q;
    if (cyc_q == CYC_W'(CYCLE_LEN - 1)) begin
      cyc_d  = '0;
      tick_d = 1'b1;
      blk_d  = i_block;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cyc_q  <= '0;
      tick_q <= 1'b0;
      blk_q  <= 1'b0;
    end else if (i_ce) begin
      cyc_q  <= cyc_d;
      tick_q <= tick_d;
      blk_q  <= blk_d;
    end
  end

  // ==========================================================
  // stage state machine and definite time counters
  cond_t             st_q, st_d;
  logic [TIME_W-1:0] trem_q, trem_d;
  logic [TIME_W-1:0] arem_q, arem_d;
  logic              astart_q, astart_d;
  logic              alarm_q, alarm_d;
  logic              inrush;

  // one stage only; the trip path alone sees the inrush inhibit
  assign inrush = i_inrush_en && (i_harm_ratio >= i_harm_limit);

  always_comb begin
    st_d     = st_q;
    trem_d   = trem_q;
    arem_d   = arem_q;
    astart_d = astart_q;
    alarm_d  = alarm_q;
    if (tick_q) begin
      case (st_q)
        ST_NORMAL: begin
          if (i_trip_pickup && blk_q) begin
            st_d = ST_BLOCKED;
          end else if (i_trip_pickup) begin
            st_d   = ST_START;
            trem_d = i_trip_delay;
          end
        end
        ST_START: begin
          if (!i_trip_pickup || blk_q) begin
            st_d   = ST_NORMAL;
            trem_d = '0;
          end else if (trem_q != '0) begin
            trem_d = trem_q - 1'b1;
          end else if (!inrush) begin
            st_d = ST_TRIP;
          end
        end
        ST_TRIP: begin
          if (!i_trip_pickup || blk_q) begin
            st_d = ST_NORMAL;
          end
        end
        ST_BLOCKED: begin
          if (!i_trip_pickup) begin
            st_d = ST_NORMAL;
          end
        end
        default: st_d = ST_NORMAL;
      endcase
      // alarm path: same blocking, no inrush inhibit
      if (!i_alarm_pickup || blk_q) begin
        astart_d = 1'b0;
        alarm_d  = 1'b0;
        arem_d   = '0;
      end else if (!astart_q) begin
        astart_d = 1'b1;
        arem_d   = i_alarm_delay;
      end else if (arem_q != '0) begin
        arem_d = arem_q - 1'b1;
      end else begin
        alarm_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q     <= ST_NORMAL;
      trem_q   <= '0;
      arem_q   <= '0;
      astart_q <= 1'b0;
      alarm_q  <= 1'b0;
    end else if (i_ce) begin
      st_q     <= st_d;
      trem_q   <= trem_d;
      arem_q   <= arem_d;
      astart_q <= astart_d;
      alarm_q  <= alarm_d;
    end
  end

  // ==========================================================
  // status outputs, registered copies for I/O and user logic
  logic start_now, trip_now, blkd_now;
  assign start_now = (st_q == ST_START) || (st_q == ST_TRIP);
  assign trip_now  = (st_q == ST_TRIP);
  assign blkd_now  = (st_q == ST_BLOCKED);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_alarm_start     <= 1'b0;
      o_alarm           <= 1'b0;
      o_start           <= 1'b0;
      o_trip            <= 1'b0;
      o_blocked         <= 1'b0;
      o_condition       <= ST_NORMAL;
      o_trip_remaining  <= '0;
      o_alarm_remaining <= '0;
    end else if (i_ce) begin
      o_alarm_start     <= astart_q;
      o_alarm           <= alarm_q;
      o_start           <= start_now;
      o_trip            <= trip_now;
      o_blocked         <= blkd_now;
      o_condition       <= st_q;
      o_trip_remaining  <= (st_q == ST_START) ? trem_q : '0;
      o_alarm_remaining <= (astart_q && !alarm_q) ? arem_q : '0;
    end
  end

  // ==========================================================
  // event detection and one-per-clock emission
  logic [NUM_EVT-1:0]   now_v, prev_q, prev_d;
  logic [2*NUM_EVT-1:0] pend_q, pend_d, new_ev, grant;
  logic [STAMP_W-1:0]   stamp_q, stamp_d;
  logic                 ev_v_d;
  logic [EVC_W-1:0]     ev_c_d;
  logic                 prev_blk_q, prev_blk_d;

  assign now_v = {i_compensating, i_unb_bank_b, i_unb_bank_a,
                  trip_now, start_now, alarm_q, astart_q};

  // changes are compared once per clock; pending bits drain lowest first,
  // far faster than a program cycle, so nothing needs a deeper queue
  always_comb begin
    prev_d     = prev_q;
    prev_blk_d = prev_blk_q;
    stamp_d    = stamp_q;
    new_ev     = '0;
    grant      = '0;
    ev_v_d     = 1'b0;
    ev_c_d     = '0;
    for (int i = 0; i < NUM_EVT; i++) begin
      new_ev[2*i]   = i_evt_on_en[i] & now_v[i] & ~prev_q[i];
      new_ev[2*i+1] = i_evt_off_en[i] & prev_q[i] & ~now_v[i];
    end
    for (int i = 2 * NUM_EVT - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        ev_c_d = EVC_W'(i);
      end
    end
    if (pend_q != '0) begin
      ev_v_d = 1'b1;
      grant[ev_c_d] = 1'b1;
    end
    if (new_ev != '0) begin
      stamp_d = i_time_stamp;
    end
    prev_d     = now_v;
    prev_blk_d = blkd_now;
    pend_d     = (pend_q & ~grant) | new_ev; // set wins over drain
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_q      <= '0;
      prev_blk_q  <= 1'b0;
      pend_q      <= '0;
      stamp_q     <= '0;
      o_evt_valid <= 1'b0;
      o_evt_code  <= '0;
      o_evt_stamp <= '0;
    end else if (i_ce) begin
      prev_q      <= prev_d;
      prev_blk_q  <= prev_blk_d;
      pend_q      <= pend_d;
      stamp_q     <= stamp_d;
      o_evt_valid <= ev_v_d;
      o_evt_code  <= ev_c_d;
      o_evt_stamp <= (new_ev != '0) ? i_time_stamp : stamp_q;
    end
  end

  // ==========================================================
  // cumulative counters, one per counted event
  logic [NUM_CNT-1:0] cnt_hit;
  assign cnt_hit = {went_on(prev_blk_q, blkd_now),
                    went_on(prev_q[EV_TRIP], now_v[EV_TRIP]),
                    went_on(prev_q[EV_START], now_v[EV_START]),
                    went_on(prev_q[EV_ALARM], now_v[EV_ALARM]),
                    went_on(prev_q[EV_ALM_START], now_v[EV_ALM_START])};

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CNT; gc++) begin : g_cnt
      logic [CNT_W-1:0] c_q, c_d;
      // a clear in the same clock as a hit leaves the count at one
      always_comb begin
        c_d = c_q;
        if (i_cnt_clear[gc]) begin
          c_d = '0;
        end
        if (cnt_hit[gc]) begin
          c_d = c_d + 1'b1;
        end
      end
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          c_q <= '0;
          o_counters[gc*CNT_W +: CNT_W] <= '0;
        end else if (i_ce) begin
          c_q <= c_d;
          o_counters[gc*CNT_W +: CNT_W] <= c_d;
        end
      end
    end
  endgenerate

  // ==========================================================
  // operation record ring
  logic [REC_W-1:0] rec_mem [DEPTH];
  logic [3:0]       wptr_q, wptr_d, num_q, num_d;
  logic             rec_we;
  logic [1:0]       rec_kind;
  logic [REC_W-1:0] rec_word, rd_word;

  // capture on the on-going edge of start, trip or blocked only
  always_comb begin
    rec_we   = 1'b0;
    rec_kind = ST_NORMAL;
    if (went_on(prev_q[EV_TRIP], now_v[EV_TRIP])) begin
      rec_we   = 1'b1;
      rec_kind = ST_TRIP;
    end else if (went_on(prev_q[EV_START], now_v[EV_START])) begin
      rec_we   = 1'b1;
      rec_kind = ST_START;
    end else if (went_on(prev_blk_q, blkd_now)) begin
      rec_we   = 1'b1;
      rec_kind = ST_BLOCKED;
    end
    rec_word = {i_time_stamp, rec_kind, i_fault_side_b, i_unb_current,
                i_fuse_ops_a, i_fuse_ops_b, trem_q, i_set_group};
    wptr_d = wptr_q;
    num_d  = num_q;
    if (rec_we) begin
      wptr_d = (wptr_q == 4'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
      num_d  = (num_q == 4'(DEPTH)) ? num_q : num_q + 1'b1;
    end
    rd_word = (i_rec_idx < 4'(DEPTH)) ? rec_mem[i_rec_idx] : '0;
  end

  always_ff @(posedge i_clk) begin
    if (i_ce && rec_we) begin
      rec_mem[wptr_q] <= rec_word;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wptr_q <= '0;
      num_q  <= '0;
      o_rec_count <= '0;
      {o_rec_stamp, o_rec_kind, o_rec_side_b, o_rec_current,
       o_rec_fuse_a, o_rec_fuse_b, o_rec_remaining, o_rec_group} <= '0;
    end else if (i_ce) begin
      wptr_q <= wptr_d;
      num_q  <= num_d;
      o_rec_count <= num_d;
      // slots not yet written read as zero through the valid count
      {o_rec_stamp, o_rec_kind, o_rec_side_b, o_rec_current,
       o_rec_fuse_a, o_rec_fuse_b, o_rec_remaining, o_rec_group} <=
        (i_rec_idx < num_q) ? rd_word : '0;
    end
  end

endmodule
`default_nettype wire

// file: pkg/nub_pkg.sv
// constants and types for the neutral unbalance block and event logic
`default_nettype none
package nub_pkg;
  // ==========================================================
  // clock and program cycle
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned CLK_PER_US   = CLK_HZ / 1_000_000;
  localparam int unsigned CYCLE_US     = 5000;  // program cycle 5 ms
  localparam int unsigned CYCLE_CLKS   = CYCLE_US * CLK_PER_US;
  // ==========================================================
  // timing of delays, one step per program cycle
  localparam int unsigned STEP_MS      = 5;     // 0.005 s resolution
  localparam int unsigned MAX_DELAY_MS = 1_800_000;
  localparam int unsigned MAX_STEPS    = MAX_DELAY_MS / STEP_MS;
  localparam int unsigned TIME_W       = $clog2(MAX_STEPS + 1);
  localparam int unsigned BLOCK_LEAD_MS = 5;    // block must lead trip
  // ==========================================================
  // inrush ratio in 0.01 percent of fundamental
  localparam int unsigned RATIO_MAX    = 5000;  // 50.00 percent
  localparam int unsigned RATIO_W      = $clog2(RATIO_MAX + 1);
  // ==========================================================
  // events: bit positions in on/off masks
  localparam int unsigned NUM_EVT      = 7;
  localparam int unsigned EV_ALM_START = 0;
  localparam int unsigned EV_ALARM     = 1;
  localparam int unsigned EV_START     = 2;
  localparam int unsigned EV_TRIP      = 3;
  localparam int unsigned EV_UNB_A     = 4;
  localparam int unsigned EV_UNB_B     = 5;
  localparam int unsigned EV_COMP      = 6;
  localparam int unsigned EVC_W        = 4;     // code = 2*event + off
  // ==========================================================
  // cumulative counters
  localparam int unsigned NUM_CNT      = 5;     // 4 events + blocked
  localparam int unsigned CNT_BLOCKED  = 4;
  // ==========================================================
  // operation record store
  localparam int unsigned REC_DEPTH    = 12;
  localparam int unsigned NUM_STAGES   = 1;
  // stage condition, also the record kind
  typedef enum logic [1:0] {
    ST_NORMAL  = 2'b00,
    ST_START   = 2'b01,
    ST_TRIP    = 2'b10,
    ST_BLOCKED = 2'b11
  } cond_t;
endpackage
`default_nettype wire

// file: dv/nub_chk.sv
// checker bound to the neutral unbalance stage ports
`default_nettype none
module nub_chk
  import nub_pkg::*;
(
  input wire logic               i_clk,
  input wire logic               i_resetn,
  input wire logic               i_inrush_en,
  input wire logic [RATIO_W-1:0] i_harm_ratio,
  input wire logic [RATIO_W-1:0] i_harm_limit,
  input wire logic               o_start,
  input wire logic               o_trip,
  input wire logic               o_blocked,
  input wire logic [1:0]         o_condition,
  input wire logic [TIME_W-1:0]  o_trip_remaining,
  input wire logic [3:0]         o_rec_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // one domain, reset silences every check
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  // ====
  // status levels agree with the reported condition
  chk_start_level: assert property (
    o_condition == ST_START |-> o_start && !o_trip && !o_blocked)
    else $error("start condition with wrong levels");
  chk_trip_level: assert property (
    o_trip |-> o_start && o_condition == ST_TRIP)
    else $error("trip without trip condition");
  chk_blocked_level: assert property (
    o_blocked |-> !o_start && o_condition == ST_BLOCKED)
    else $error("blocked while timing");
  chk_start_release: assert property (
    $fell(o_start) |-> o_condition == ST_NORMAL)
    else $error("start left to a state other than normal");
  // ====
  // remaining time only counts in start, one step per tick
  chk_remaining_idle: assert property (
    o_condition != ST_START |-> o_trip_remaining == '0)
    else $error("remaining time outside start");
  chk_remaining_step: assert property (
    o_condition == ST_START && $past(o_condition) == ST_START
    && $changed(o_trip_remaining)
    |-> o_trip_remaining == $past(o_trip_remaining) - 1'b1)
    else $error("remaining time not one step down");
  // ====
  // records grow by one, only with a new start, trip or block
  chk_record_step: assert property (
    $changed(o_rec_count) |-> o_rec_count == $past(o_rec_count) + 4'h1
    && ($rose(o_start) || $rose(o_trip) || $rose(o_blocked)))
    else $error("record count moved without cause");
  chk_record_cap: assert property (
    o_rec_count <= 4'hc)
    else $error("record count above store depth");
  // inrush holds the trip back, never the alarm
  chk_inrush_hold: assert property (
    $rose(o_trip) |-> !(i_inrush_en && i_harm_ratio >= i_harm_limit))
    else $error("trip while inrush restraint active");
endmodule
bind neutral_unbalance_event_source nub_chk nub_chk_i (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_inrush_en(i_inrush_en),
  .i_harm_ratio(i_harm_ratio), .i_harm_limit(i_harm_limit),
  .o_start(o_start), .o_trip(o_trip), .o_blocked(o_blocked),
  .o_condition(o_condition), .o_trip_remaining(o_trip_remaining),
  .o_rec_count(o_rec_count)
);
`default_nettype wire

// file: dv/nub_far_end.sv
// far side model: pick-up element, blocking matrix, time source
`default_nettype none
module nub_far_end (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_want_alarm,
  input  wire logic        i_want_trip,
  input  wire logic        i_want_block,
  output logic             o_alarm_pickup,
  output logic             o_trip_pickup,
  output logic             o_block,
  output logic [63:0]      o_time_stamp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // levels retimed like the matrix; stamp free-running so each
  // event change sees a distinct value
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_alarm_pickup <= 1'b0;
      o_trip_pickup  <= 1'b0;
      o_block        <= 1'b0;
      o_time_stamp   <= '0;
    end else begin
      o_alarm_pickup <= i_want_alarm;
      o_trip_pickup  <= i_want_trip;
      o_block        <= i_want_block;
      o_time_stamp   <= o_time_stamp + 64'h1;
    end
  end
endmodule
`default_nettype wire

// file: dv/neutral_unbalance_event_source_tb.sv
// self-checking bench for the neutral unbalance stage
`default_nettype none
module neutral_unbalance_event_source_tb
  import nub_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CYC = 8; // short program cycle keeps run brief
  // ====
  // stimulus and observed outputs
  logic               i_clk = 1'b0;
  logic               i_resetn = 1'b0;
  logic               want_alarm = 1'b0;
  logic               want_trip = 1'b0;
  logic               want_block = 1'b0;
  logic               i_inrush_en = 1'b0;
  logic [RATIO_W-1:0] i_harm_ratio = '0;
  logic [RATIO_W-1:0] i_harm_limit = 13'h07d0;
  logic [TIME_W-1:0]  i_alarm_delay = '0;
  logic [TIME_W-1:0]  i_trip_delay = '0;
  logic [2:0]         unb = '0; // bank a, bank b, compensating
  logic [15:0]        i_unb_current = '0;
  logic [NUM_EVT-1:0] i_evt_on_en = 7'h7f;
  logic [NUM_EVT-1:0] i_evt_off_en = 7'h7f;
  logic [NUM_CNT-1:0] i_cnt_clear = '0;
  logic [3:0]         i_rec_idx = '0;
  logic               alarm_pu;
  logic               trip_pu;
  logic               blk;
  logic [63:0]        stamp;
  logic [63:0]        o_evt_stamp;
  logic [5:0]         lvl; // alarm start, alarm, start, trip, blocked, valid
  logic [1:0]         o_condition;
  logic [1:0]         o_rec_kind;
  logic [TIME_W-1:0]  o_trip_remaining;
  logic [3:0]         o_evt_code;
  logic [3:0]         o_rec_count;
  logic [79:0]        o_counters;
  logic [15:0]        o_rec_current;
  logic [3:0]         evq[$];
  int                 miscompares = 0;
  int                 total_checks = 0;

  always #5 i_clk = ~i_clk;

  nub_far_end nub_far_end_i (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_want_alarm(want_alarm),
    .i_want_trip(want_trip), .i_want_block(want_block),
    .o_alarm_pickup(alarm_pu), .o_trip_pickup(trip_pu), .o_block(blk),
    .o_time_stamp(stamp));
  neutral_unbalance_event_source #(.CYCLE_LEN(CYC))
    neutral_unbalance_event_source_i (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1),
    .i_alarm_pickup(alarm_pu), .i_trip_pickup(trip_pu), .i_block(blk),
    .i_inrush_en(i_inrush_en), .i_harm_ratio(i_harm_ratio),
    .i_harm_limit(i_harm_limit), .i_alarm_delay(i_alarm_delay),
    .i_trip_delay(i_trip_delay), .i_unb_bank_a(unb[0]),
    .i_unb_bank_b(unb[1]), .i_compensating(unb[2]),
    .i_time_stamp(stamp), .i_fault_side_b(1'b0),
    .i_unb_current(i_unb_current), .i_fuse_ops_a(8'h03),
    .i_fuse_ops_b(8'h04), .i_set_group(3'h2), .i_evt_on_en(i_evt_on_en),
    .i_evt_off_en(i_evt_off_en), .i_cnt_clear(i_cnt_clear),
    .i_rec_idx(i_rec_idx), .o_alarm_start(lvl[0]), .o_alarm(lvl[1]),
    .o_start(lvl[2]), .o_trip(lvl[3]), .o_blocked(lvl[4]),
    .o_condition(o_condition), .o_trip_remaining(o_trip_remaining),
    .o_alarm_remaining(), .o_evt_valid(lvl[5]), .o_evt_code(o_evt_code),
    .o_evt_stamp(o_evt_stamp), .o_counters(o_counters),
    .o_rec_count(o_rec_count), .o_rec_stamp(), .o_rec_kind(o_rec_kind),
    .o_rec_side_b(), .o_rec_current(o_rec_current), .o_rec_fuse_a(),
    .o_rec_fuse_b(), .o_rec_remaining(), .o_rec_group());
  // ====
  // helpers: compare, bounded wait on a status level, event lookup
  task automatic check(input logic [79:0] got, input logic [79:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic wait_for(input int k, input logic v, output int n);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (lvl[k] !== v && n < 400);
    if (lvl[k] !== v) check(lvl[k], v);
  endtask
  function automatic logic seen(input int c);
    foreach (evq[i]) if (evq[i] == c) return 1'b1;
    return 1'b0;
  endfunction
  // logged events; a stamp far behind the time source is stale
  always @(posedge i_clk) begin
    if (lvl[5] === 1'b1) begin
      evq.push_back(o_evt_code);
      check(stamp - o_evt_stamp < 64'h10, 1'b1);
    end
  end
  // ====
  // scenarios
  task automatic t_trip();
    int n;
    i_trip_delay <= 19'h2;
    want_trip    <= 1'b1;
    wait_for(2, 1'b1, n);
    check(o_condition, ST_START);
    check(o_trip_remaining, 19'h2);
    wait_for(3, 1'b1, n);
    check(n, 3 * CYC);
    check(o_counters[47:32], 16'h1);
    check(o_counters[63:48], 16'h1);
    want_trip <= 1'b0;
    wait_for(2, 1'b0, n);
    repeat (4) @(posedge i_clk);
    check(seen(4) && seen(5) && seen(6) && seen(7), 1'b1);
    $display("test trip done");
  endtask
  task automatic t_blocked();
    int n;
    // block leads pick-up by a full program cycle so the tick sees it
    want_block <= 1'b1;
    repeat (CYC + 1) @(posedge i_clk);
    want_trip  <= 1'b1;
    wait_for(4, 1'b1, n);
    check(o_condition, ST_BLOCKED);
    i_rec_idx <= 4'h2;
    repeat (4 * CYC) @(posedge i_clk);
    check(lvl[3:2], 2'b00);
    check(o_counters[79:64], 16'h1);
    check(o_rec_kind, ST_BLOCKED);
    want_trip  <= 1'b0;
    want_block <= 1'b0;
    wait_for(4, 1'b0, n);
    $display("test blocked done");
  endtask
  task automatic t_release();
    int n;
    evq.delete();
    i_trip_delay <= 19'ha;
    want_trip    <= 1'b1;
    wait_for(2, 1'b1, n);
    repeat (CYC) @(posedge i_clk);
    want_block <= 1'b1;
    wait_for(2, 1'b0, n);
    check(n <= 2 * CYC + 2, 1'b1);
    check(o_condition, ST_NORMAL);
    repeat (4) @(posedge i_clk);
    check({seen(5), lvl[3]}, 2'b10);
    want_trip  <= 1'b0;
    want_block <= 1'b0;
    repeat (3 * CYC) @(posedge i_clk);
    $display("test release done");
  endtask
  task automatic t_inrush();
    int n;
    i_inrush_en   <= 1'b1;
    i_harm_ratio  <= 13'h07d0; // equal to the limit
    i_trip_delay  <= '0;
    i_alarm_delay <= 19'h1;
    want_alarm    <= 1'b1;
    want_trip     <= 1'b1;
    wait_for(0, 1'b1, n);
    wait_for(1, 1'b1, n);
    check(n, 2 * CYC);
    repeat (5 * CYC) @(posedge i_clk);
    check({o_condition, lvl[1]}, {ST_START, 1'b1});
    i_harm_ratio <= 13'h07cf;
    wait_for(3, 1'b1, n);
    check(n <= CYC + 3, 1'b1);
    i_inrush_en <= 1'b0;
    want_alarm  <= 1'b0;
    want_trip   <= 1'b0;
    wait_for(2, 1'b0, n);
    $display("test inrush done");
  endtask
  task automatic t_events();
    // let off events of the previous test drain before clearing the log
    repeat (8) @(posedge i_clk);
    evq.delete();
    i_evt_on_en <= 7'h6f; // bank a rising edge not logged
    unb         <= 3'h7;
    repeat (3 * CYC) @(posedge i_clk);
    unb <= 3'h0;
    repeat (3 * CYC) @(posedge i_clk);
    check(seen(8), 1'b0);
    check(evq.size(), 5);
    check(seen(9) && seen(10) && seen(13), 1'b1);
    i_evt_on_en <= 7'h7f;
    $display("test events done");
  endtask
  task automatic t_records();
    int n;
    int i;
    i_resetn     <= 1'b0;
    i_trip_delay <= 19'h5;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (i = 0; i < 13; i++) begin
      i_unb_current <= 16'h0100 + 16'(i);
      want_trip     <= 1'b1;
      wait_for(2, 1'b1, n);
      want_trip <= 1'b0;
      wait_for(2, 1'b0, n);
    end
    check(o_rec_count, 4'hc);
    check(o_counters[47:32], 16'hd);
    i_rec_idx <= 4'h0;
    repeat (2) @(posedge i_clk);
    check({o_rec_current, o_rec_kind}, {16'h010c, ST_START});
    i_rec_idx <= 4'h1;
    repeat (2) @(posedge i_clk);
    check(o_rec_current, 16'h0101);
    i_cnt_clear <= 5'h1f;
    repeat (2) @(posedge i_clk);
    check(o_counters, 80'h0);
    i_cnt_clear <= '0;
    $display("test records done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ====
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_trip();
    t_blocked();
    t_release();
    t_inrush();
    t_events();
    t_records();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
